// file: rtl/gel_edge_irq_mapper.v
// edge interrupt and programmable logic section of a 16-pin gpio expander
// Behaviour
// - reset clears detection, interrupt pin released
// - interrupt mask resets to all ones
// - transition flags reset cleared
// - unmasked matching edge pulls interrupt low
// - source register shows which pins interrupted
// - writing all ones clears that bank's source and flags, interrupt once neither bank has a source bit set
// - option: pin value read clears interrupt
// - mask bit zero enables that pin
// - two-bit sense field per pin
// - truth tables: four 3-in or two 3-to-2
// - unclaimed pins GPIO, claimed direction forced
// - direction ignored by logic, pins still readable
// - low mode codes 01 and 10 claim pins 0-2 and 0-3
// - code 11 claims pins 0-4, ignores upper
// - upper mode field claims pins 4-6 (code 01) or 4-7 (code 10)
// - each bank has its own mode register
// - two-input output indexes table zero (low field) or table two (upper field)
// - writing one clears single source bit
// - sense codes none, rising, falling, both
`timescale 1ns/100ps
`default_nettype none
`include "gel_defines.vh"
module gel_edge_irq_mapper #(
  parameter NPIN = 16
) (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_bank_i,
  output reg [7:0] reg_rdata_o,
  input wire [15:0] pin_in_i,
  output wire [15:0] pin_out_o,
  output wire [15:0] pin_oe_o,
  output wire interrupt_out_n_o,
  output wire interrupt_out_n_oe_o
);
  ////////////////////////////////////////////////////////////////////////
  // registers, two banks: index 0 is bank a (pins 0-7), 1 is bank b
  reg [15:0] data_reg;
  reg [15:0] direction_reg;
  reg [15:0] irq_mask_reg;
  reg [31:0] edge_sense_reg;
  reg [15:0] irq_source_reg;
  reg [15:0] event_flag_reg;
  reg [7:0] extra_options_reg;
  reg [7:0] logic_mode_bank_a;
  reg [7:0] logic_mode_bank_b;
  reg [7:0] tbl_a0;
  reg [7:0] tbl_a1;
  reg [7:0] tbl_a2;
  reg [7:0] tbl_a3;
  reg [7:0] tbl_b0;
  reg [7:0] tbl_b1;
  reg [7:0] tbl_b2;
  reg [7:0] tbl_b3;
  reg [15:0] pin_meta;
  reg [15:0] pin_sync;
  reg [15:0] pin_prev;

  ////////////////////////////////////////////////////////////////////////
  // programmable logic, one instance per bank
  wire [7:0] claim_a;
  wire [7:0] claim_b;
  wire [7:0] isout_a;
  wire [7:0] isout_b;
  wire [7:0] val_a;
  wire [7:0] val_b;
  wire [15:0] claim;
  wire [15:0] is_out;
  wire [15:0] logic_val;

  gel_logic_bank u_bank_a (
    .pin_i(pin_in_i[7:0]),
    .logic_mode_i(logic_mode_bank_a),
    .table0_i(tbl_a0),
    .table1_i(tbl_a1),
    .table2_i(tbl_a2),
    .table3_i(tbl_a3),
    .claim_o(claim_a),
    .is_out_o(isout_a),
    .value_o(val_a)
  );

  gel_logic_bank u_bank_b (
    .pin_i(pin_in_i[15:8]),
    .logic_mode_i(logic_mode_bank_b),
    .table0_i(tbl_b0),
    .table1_i(tbl_b1),
    .table2_i(tbl_b2),
    .table3_i(tbl_b3),
    .claim_o(claim_b),
    .is_out_o(isout_b),
    .value_o(val_b)
  );

  assign claim = {claim_b, claim_a};
  assign is_out = {isout_b, isout_a};
  assign logic_val = {val_b, val_a};

  // claimed pins take direction from their role, others from direction_reg
  assign pin_oe_o = (claim & is_out) | (~claim & ~direction_reg);
  assign pin_out_o = (claim & is_out & logic_val) | (~claim & data_reg);

  ////////////////////////////////////////////////////////////////////////
  // edge detection
  function edge_hit;
    input [1:0] sense;
    input prev;
    input cur;
    begin
      case (sense)
        `GEL_SENSE_RISE: edge_hit = ~prev & cur;
        `GEL_SENSE_FALL: edge_hit = prev & ~cur;
        `GEL_SENSE_BOTH: edge_hit = prev ^ cur;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  reg [15:0] edge_now;
  integer k;
  always @* begin
    edge_now = 16'h0000;
    for (k = 0; k < NPIN; k = k + 1) begin
      edge_now[k] = edge_hit(edge_sense_reg[2*k +: 2], pin_prev[k],
                             pin_sync[k]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register access decode
  wire bank_b;
  wire wr_a;
  wire wr_b;
  wire [15:0] wr_word;
  assign bank_b = reg_bank_i[0];
  assign wr_a = reg_wr_i & ~bank_b;
  assign wr_b = reg_wr_i & bank_b;
  assign wr_word = bank_b ? {reg_wdata_i, 8'h00} : {8'h00, reg_wdata_i};

  wire src_wr;
  wire auto_clr;
  reg [15:0] clr_mask;
  assign src_wr = reg_wr_i & (reg_addr_i == `GEL_ADDR_SOURCE);
  assign auto_clr = reg_rd_i & (reg_addr_i == `GEL_ADDR_DATA) &
                    extra_options_reg[`GEL_OPT_AUTOCLR_BIT];
  always @* begin
    clr_mask = 16'h0000;
    if (src_wr) begin
      clr_mask = wr_word;
    end
    if (auto_clr) begin
      clr_mask = 16'hFFFF;
    end
  end

  wire [15:0] hit;
  assign hit = edge_now & ~irq_mask_reg;

  ////////////////////////////////////////////////////////////////////////
  // input synchroniser; only pin_sync may read pin_meta
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
      pin_prev <= 16'h0000;
    end else begin
      pin_meta <= pin_in_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event and source flags
  reg [15:0] next_source;
  reg [15:0] next_event;
  always @* begin
    // a new edge wins over a clear in the same cycle
    next_source = (irq_source_reg & ~clr_mask) | hit;
    next_event = (event_flag_reg & ~clr_mask) | edge_now;
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_source_reg <= 16'h0000;
      event_flag_reg <= 16'h0000;
    end else begin
      irq_source_reg <= next_source;
      event_flag_reg <= next_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers, written one bank half at a time
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_reg <= {`GEL_RST_DATA, `GEL_RST_DATA};
      direction_reg <= {`GEL_RST_DIR, `GEL_RST_DIR};
      irq_mask_reg <= {`GEL_RST_MASK, `GEL_RST_MASK};
      edge_sense_reg <= 32'h00000000;
      extra_options_reg <= `GEL_RST_ZERO;
      logic_mode_bank_a <= `GEL_RST_ZERO;
      logic_mode_bank_b <= `GEL_RST_ZERO;
      tbl_a0 <= `GEL_RST_ZERO;
      tbl_a1 <= `GEL_RST_ZERO;
      tbl_a2 <= `GEL_RST_ZERO;
      tbl_a3 <= `GEL_RST_ZERO;
      tbl_b0 <= `GEL_RST_ZERO;
      tbl_b1 <= `GEL_RST_ZERO;
      tbl_b2 <= `GEL_RST_ZERO;
      tbl_b3 <= `GEL_RST_ZERO;
    end else begin
      if (wr_a) begin
        case (reg_addr_i)
          `GEL_ADDR_DATA: data_reg[7:0] <= reg_wdata_i;
          `GEL_ADDR_DIR: direction_reg[7:0] <= reg_wdata_i;
          `GEL_ADDR_MASK: irq_mask_reg[7:0] <= reg_wdata_i;
          `GEL_ADDR_SENSE_HIGH: edge_sense_reg[15:8] <= reg_wdata_i;
          `GEL_ADDR_SENSE_LOW: edge_sense_reg[7:0] <= reg_wdata_i;
          `GEL_ADDR_OPTIONS: extra_options_reg <= reg_wdata_i;
          `GEL_ADDR_MODE: logic_mode_bank_a <= reg_wdata_i;
          `GEL_ADDR_TABLE0: tbl_a0 <= reg_wdata_i;
          `GEL_ADDR_TABLE1: tbl_a1 <= reg_wdata_i;
          `GEL_ADDR_TABLE2: tbl_a2 <= reg_wdata_i;
          `GEL_ADDR_TABLE3: tbl_a3 <= reg_wdata_i;
          default: tbl_a3 <= tbl_a3;
        endcase
      end
      if (wr_b) begin
        case (reg_addr_i)
          `GEL_ADDR_DATA: data_reg[15:8] <= reg_wdata_i;
          `GEL_ADDR_DIR: direction_reg[15:8] <= reg_wdata_i;
          `GEL_ADDR_MASK: irq_mask_reg[15:8] <= reg_wdata_i;
          `GEL_ADDR_SENSE_HIGH: edge_sense_reg[31:24] <= reg_wdata_i;
          `GEL_ADDR_SENSE_LOW: edge_sense_reg[23:16] <= reg_wdata_i;
          `GEL_ADDR_OPTIONS: extra_options_reg <= reg_wdata_i;
          `GEL_ADDR_MODE: logic_mode_bank_b <= reg_wdata_i;
          `GEL_ADDR_TABLE0: tbl_b0 <= reg_wdata_i;
          `GEL_ADDR_TABLE1: tbl_b1 <= reg_wdata_i;
          `GEL_ADDR_TABLE2: tbl_b2 <= reg_wdata_i;
          `GEL_ADDR_TABLE3: tbl_b3 <= reg_wdata_i;
          default: tbl_b3 <= tbl_b3;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, combinational from the current address and bank
  // pick the half of a 16-bit register that the bank select names
  function [7:0] bank_half;
    input [15:0] full;
    input sel;
    begin
      bank_half = sel ? full[15:8] : full[7:0];
    end
  endfunction

  always @* begin
    reg_rdata_o = 8'h00;
    case (reg_addr_i)
      `GEL_ADDR_DATA:
        reg_rdata_o = bank_half(pin_sync, bank_b);
      `GEL_ADDR_DIR:
        reg_rdata_o = bank_half(direction_reg, bank_b);
      `GEL_ADDR_MASK:
        reg_rdata_o = bank_half(irq_mask_reg, bank_b);
      `GEL_ADDR_SENSE_HIGH:
        reg_rdata_o = bank_b ? edge_sense_reg[31:24] : edge_sense_reg[15:8];
      `GEL_ADDR_SENSE_LOW:
        reg_rdata_o = bank_b ? edge_sense_reg[23:16] : edge_sense_reg[7:0];
      `GEL_ADDR_SOURCE:
        reg_rdata_o = bank_half(irq_source_reg, bank_b);
      `GEL_ADDR_EVENT:
        reg_rdata_o = bank_half(event_flag_reg, bank_b);
      `GEL_ADDR_OPTIONS: reg_rdata_o = extra_options_reg;
      `GEL_ADDR_MODE:
        reg_rdata_o = bank_b ? logic_mode_bank_b : logic_mode_bank_a;
      `GEL_ADDR_TABLE0: reg_rdata_o = bank_b ? tbl_b0 : tbl_a0;
      `GEL_ADDR_TABLE1: reg_rdata_o = bank_b ? tbl_b1 : tbl_a1;
      `GEL_ADDR_TABLE2: reg_rdata_o = bank_b ? tbl_b2 : tbl_a2;
      `GEL_ADDR_TABLE3: reg_rdata_o = bank_b ? tbl_b3 : tbl_a3;
      default: reg_rdata_o = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // open-drain interrupt: drive low only while a source bit is set
  assign interrupt_out_n_o = 1'b0;
  assign interrupt_out_n_oe_o = |irq_source_reg;
endmodule // gel_edge_irq_mapper
`default_nettype wire

// file: rtl/gel_defines.vh
// offsets, field positions, reset values and codes of the gpio edge/logic block
`ifndef GEL_DEFINES_VH
`define GEL_DEFINES_VH
`define GEL_ADDR_DATA 8'h00
`define GEL_ADDR_DIR 8'h01
`define GEL_ADDR_MASK 8'h05
`define GEL_ADDR_SENSE_HIGH 8'h06
`define GEL_ADDR_SENSE_LOW 8'h07
`define GEL_ADDR_SOURCE 8'h08
`define GEL_ADDR_EVENT 8'h09
`define GEL_ADDR_OPTIONS 8'h0A
`define GEL_ADDR_MODE 8'h10
`define GEL_ADDR_TABLE0 8'h11
`define GEL_ADDR_TABLE1 8'h12
`define GEL_ADDR_TABLE2 8'h13
`define GEL_ADDR_TABLE3 8'h14
`define GEL_RST_DATA 8'hFF
`define GEL_RST_DIR 8'hFF
`define GEL_RST_MASK 8'hFF
`define GEL_RST_ZERO 8'h00
`define GEL_SENSE_NONE 2'h0
`define GEL_SENSE_RISE 2'h1
`define GEL_SENSE_FALL 2'h2
`define GEL_SENSE_BOTH 2'h3
`define GEL_MODE_GPIO 2'h0
`define GEL_MODE_TWO_IN 2'h1
`define GEL_MODE_THREE_IN 2'h2
`define GEL_MODE_THREE_TWO 2'h3
`define GEL_MODE_LO_LSB 0
`define GEL_MODE_HI_LSB 4
`define GEL_OPT_AUTOCLR_BIT 0
`endif

// file: rtl/gel_logic_bank.v
// combinational programmable logic for one eight-pin bank
`timescale 1ns/100ps
`default_nettype none
`include "gel_defines.vh"
module gel_logic_bank (
  input wire [7:0] pin_i,
  input wire [7:0] logic_mode_i,
  input wire [7:0] table0_i,
  input wire [7:0] table1_i,
  input wire [7:0] table2_i,
  input wire [7:0] table3_i,
  output reg [7:0] claim_o,
  output reg [7:0] is_out_o,
  output reg [7:0] value_o
);
  wire [1:0] lo;
  wire [1:0] hi;
  assign lo = logic_mode_i[`GEL_MODE_LO_LSB+1:`GEL_MODE_LO_LSB];
  assign hi = logic_mode_i[`GEL_MODE_HI_LSB+1:`GEL_MODE_HI_LSB];

  // pick one bit of an eight-bit table by a three-bit index
  function pick;
    input [7:0] tbl;
    input [2:0] idx;
    begin
      pick = tbl[idx];
    end
  endfunction

  always @* begin
    claim_o = 8'h00;
    is_out_o = 8'h00;
    value_o = 8'h00;
    case (lo)
      `GEL_MODE_TWO_IN: begin
        claim_o[2:0] = 3'h7;
        is_out_o[2] = 1'b1;
        value_o[2] = pick(table0_i, {1'b0, pin_i[1:0]});
      end
      `GEL_MODE_THREE_IN: begin
        claim_o[3:0] = 4'hF;
        is_out_o[3] = 1'b1;
        value_o[3] = pick(table0_i, pin_i[2:0]);
      end
      `GEL_MODE_THREE_TWO: begin
        claim_o[4:0] = 5'h1F;
        is_out_o[4:3] = 2'h3;
        value_o[3] = pick(table0_i, pin_i[2:0]);
        value_o[4] = pick(table1_i, pin_i[2:0]);
      end
      default: begin
        claim_o[3:0] = 4'h0;
      end
    endcase
    if (lo != `GEL_MODE_THREE_TWO) begin
      case (hi)
        `GEL_MODE_TWO_IN: begin
          claim_o[6:4] = 3'h7;
          is_out_o[6] = 1'b1;
          value_o[6] = pick(table2_i, {1'b0, pin_i[5:4]});
        end
        `GEL_MODE_THREE_IN: begin
          claim_o[7:4] = 4'hF;
          is_out_o[7] = 1'b1;
          value_o[7] = pick(table2_i, pin_i[6:4]);
        end
        default: begin
          claim_o[7:4] = 4'h0;
        end
      endcase
    end
  end
endmodule // gel_logic_bank
`default_nettype wire

// file: bench/gel_edge_irq_mapper_sva.sv
// assertions on the ports of the gpio edge interrupt and logic block
`timescale 1ns/100ps
`default_nettype none
module gel_edge_irq_mapper_sva #(
  parameter NPIN = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_bank_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [15:0] pin_in_i,
  input wire logic [15:0] pin_out_o,
  input wire logic [15:0] pin_oe_o,
  input wire logic interrupt_out_n_o,
  input wire logic interrupt_out_n_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic clr_acc;
  // accesses that may clear pending sources
  assign clr_acc = (reg_wr_i && reg_addr_i == 8'h08) ||
    (reg_rd_i && reg_addr_i == 8'h00);
  a_release_idle: assert property (
    $rose(rst_b_i) |-> !interrupt_out_n_oe_o && pin_oe_o == 16'h0000)
    else $error("outputs not idle after reset");
  a_mask_start: assert property (
    $rose(rst_b_i) && reg_addr_i == 8'h05 |-> reg_rdata_o == 8'hFF)
    else $error("mask not all ones after reset");
  a_pin_low: assert property (
    interrupt_out_n_o == 1'b0)
    else $error("interrupt value not low");
  a_rise_cause: assert property (
    $rose(interrupt_out_n_oe_o) |-> $past(pin_in_i, 3) != $past(pin_in_i, 4))
    else $error("interrupt without a pin edge");
  a_oe_holds: assert property (
    interrupt_out_n_oe_o && !clr_acc |=> interrupt_out_n_oe_o)
    else $error("interrupt dropped without clear");
  a_fall_cause: assert property (
    $fell(interrupt_out_n_oe_o) |-> $past(clr_acc))
    else $error("interrupt released without access");
  a_src_shows: assert property (
    reg_addr_i == 8'h08 && reg_rdata_o != 8'h00 |-> interrupt_out_n_oe_o)
    else $error("source set but interrupt released");
  a_logic_still: assert property (
    !$past(reg_wr_i) && $stable(pin_in_i) |->
      $stable(pin_out_o) && $stable(pin_oe_o))
    else $error("pin outputs moved with inputs still");
endmodule // gel_edge_irq_mapper_sva
bind gel_edge_irq_mapper gel_edge_irq_mapper_sva #(.NPIN(NPIN))
  i_gel_edge_irq_mapper_sva (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_bank_i(reg_bank_i), .reg_rdata_o(reg_rdata_o), .pin_in_i(pin_in_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .interrupt_out_n_o(interrupt_out_n_o),
  .interrupt_out_n_oe_o(interrupt_out_n_oe_o));
`default_nettype wire

// file: bench/gel_host.sv
// host model that drives the register port of the gpio edge block
`timescale 1ns/100ps
`default_nettype none
module gel_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic [7:0] bank_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h05;
    wdata_o = 8'h00;
    bank_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write, held until the edge that takes it; also source clears
  task automatic put(input logic b, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    bank_o <= {7'h00, b};
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // one read, data taken at the edge that ends it
  task automatic get(input logic b, input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    bank_o <= {7'h00, b};
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    v = rdata_i;
    rd_o <= 1'b0;
  endtask
endmodule // gel_host
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the gpio edge interrupt and logic block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] ext = 16'h0000;
  wire logic [7:0] addr, wdata, bank, rdata;
  wire logic wr, rd, irq_n, irq_oe;
  wire logic [15:0] pin_lvl, pout, poe;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] d;
  always #25 core_clk_i = ~core_clk_i;
  // pin level seen by the block: its own drive where enabled
  assign pin_lvl = (poe & pout) | (~poe & ext);
  // interrupt line as the host sees it, with its pull-up
  wire logic irq_line;
  assign irq_line = irq_oe ? irq_n : 1'b1;
  gel_edge_irq_mapper #(.NPIN(16)) i_gel_edge_irq_mapper (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_bank_i(bank),
    .reg_rdata_o(rdata), .pin_in_i(pin_lvl), .pin_out_o(pout),
    .pin_oe_o(poe), .interrupt_out_n_o(irq_n),
    .interrupt_out_n_oe_o(irq_oe));
  gel_host i_gel_host (.clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .bank_o(bank), .wr_o(wr), .rd_o(rd));
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rchk(input logic b, input logic [7:0] a, input logic [7:0] e,
    input string w);
    i_gel_host.get(b, a, d);
    chk(w, {8'h00, e}, {8'h00, d});
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(0, 8'h05, 8'hFF, "mask a");
    rchk(1, 8'h05, 8'hFF, "mask b");
    rchk(0, 8'h08, 8'h00, "source");
    rchk(1, 8'h09, 8'h00, "events");
    chk("irq idle", 16'h0000, {15'h0, irq_oe});
    chk("irq line idle", 16'h0001, {15'h0, irq_line});
    $display("test reset done");
  endtask
  // pin 1 unmasked with sense under test, pin 2 masked with both edges
  task automatic edge_step(input logic [15:0] v, input logic [1:0] s,
    input string w);
    @(posedge core_clk_i);
    ext <= v;
    repeat (6) @(posedge core_clk_i);
    rchk(0, 8'h08, {6'h0, s}, w);
    rchk(0, 8'h09, {5'h0, 1'b1, s}, w);
    chk(w, {15'h0, s[1]}, {15'h0, irq_oe});
    chk(w, {15'h0, ~s[1]}, {15'h0, irq_line});
    i_gel_host.put(0, 8'h08, s[1] ? 8'h02 : 8'hFF);
    rchk(0, 8'h09, s[1] ? 8'h04 : 8'h00, w);
    chk(w, 16'h0000, {15'h0, irq_oe});
    chk(w, 16'h0001, {15'h0, irq_line});
  endtask
  task automatic t_edges;
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      i_gel_host.put(0, 8'h05, 8'hFD);
      i_gel_host.put(0, 8'h07, {2'h0, 2'h3, c, 2'h0});
      edge_step(16'h0006, {c[0], 1'b0}, "rise");
      edge_step(16'h0000, {c[1], 1'b0}, "fall");
    end
    $display("test edges done");
  endtask
  task automatic t_auto;
    i_gel_host.put(0, 8'h0A, 8'h01);
    i_gel_host.put(1, 8'h05, 8'hFE);
    i_gel_host.put(1, 8'h07, 8'h01);
    @(posedge core_clk_i);
    ext <= 16'h0100;
    repeat (6) @(posedge core_clk_i);
    rchk(1, 8'h08, 8'h01, "source b");
    chk("irq b", 16'h0001, {15'h0, irq_oe});
    rchk(0, 8'h00, 8'h00, "data a");
    rchk(1, 8'h08, 8'h00, "auto clear");
    chk("irq auto", 16'h0000, {15'h0, irq_oe});
    $display("test auto clear done");
  endtask
  task automatic t_logic;
    logic [24:0] t [6];
    logic [2:0] p;
    logic [1:0] q;
    t = '{{1'b0, 8'h01, 16'h0004}, {1'b0, 8'h02, 16'h0008},
      {1'b0, 8'h13, 16'h0018}, {1'b0, 8'h10, 16'h0040},
      {1'b0, 8'h20, 16'h0080}, {1'b1, 8'h21, 16'h8480}};
    for (int i = 0; i < 6; i++) begin
      i_gel_host.put(t[i][24], 8'h10, t[i][23:16]);
      @(negedge core_clk_i);
      chk("claims", t[i][15:0], poe);
    end
    i_gel_host.put(0, 8'h10, 8'h01);
    i_gel_host.put(0, 8'h11, 8'h08);
    // pin 0 asks for output but stays a logic input, pin 3 stays gpio
    i_gel_host.put(0, 8'h01, 8'hF6);
    @(negedge core_clk_i);
    chk("gpio oe", 16'h840C, poe);
    chk("gpio out", 16'h0008, pout & poe);
    i_gel_host.put(0, 8'h00, 8'hF7);
    @(negedge core_clk_i);
    chk("gpio out", 16'h0000, pout & poe);
    for (int v = 0; v < 4; v++) begin
      @(posedge core_clk_i);
      ext <= {14'h0, v[1:0]};
      @(negedge core_clk_i);
      chk("and out", {15'h0, v == 3}, {15'h0, pout[2]});
    end
    repeat (3) @(posedge core_clk_i);
    chk("logic in irq", 16'h0001, {15'h0, irq_oe});
    rchk(0, 8'h00, 8'h07, "claimed read");
    // pin 3 gives odd parity, pin 4 the majority of pins 0-2
    i_gel_host.put(0, 8'h10, 8'h13);
    i_gel_host.put(0, 8'h12, 8'hE8);
    i_gel_host.put(0, 8'h11, 8'h96);
    for (int v = 0; v < 8; v++) begin
      @(posedge core_clk_i);
      ext <= {13'h0, v[2:0]};
      p = v[2:0];
      q = {(p[0] & p[1]) | (p[0] & p[2]) | (p[1] & p[2]), ^p};
      @(negedge core_clk_i);
      chk("pair out", {14'h0, q}, {14'h0, pout[4:3]});
    end
    $display("test logic done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #4000000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_edges;
    t_auto;
    t_logic;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
